// ---- src/stop_mode_standby_control.sv ----
// stop mode standby controller: entry, wake, settle and resume
`timescale 1ns/10ps
`include "stop_ctrl_cfg.svh"
module stop_mode_standby_control #(
  parameter int SRC_N = `SRC_COUNT,
  parameter int CNT_W = `SETTLE_CNT_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic stop_exec,
  input wire logic irq_accept_on,
  input wire logic [SRC_N-1:0] irq_request,
  input wire logic [SRC_N-1:0] irq_mask,
  input wire logic subclk_runs_in_stop,
  input wire logic i2c_addr_matched,
  input wire logic [`SETTLE_SEL_W-1:0] osc_settle_time_select,
  input wire logic watchdog_enable_option,
  input wire logic watchdog_standby_run_option,
  input wire logic pll_run_bit,
  output logic main_osc_run,
  output logic cpu_clk_en,
  output logic stopped,
  output logic resume_vector,
  output logic resume_next,
  output logic wdt_osc_run,
  output logic wdt_counter_clr,
  output logic pll_run
);
  // the counter must hold the longest settle time, base shifted by 7
  if (SRC_N <= `SRC_I2C || CNT_W < $clog2(`SETTLE_BASE_CYC + 1) +
      (1 << `SETTLE_SEL_W) - 1) begin : g_bad_params
    $error("unsupported parameters");
  end

  // ------------------------------------------------------------
  // wake qualification
  // ------------------------------------------------------------
  // wake sources are external event inputs: synchronise first
  logic [SRC_N-1:0] req_s1_q;
  logic [SRC_N-1:0] req_s2_q;
  logic i2c_s1_q;
  logic i2c_s2_q;
  always_ff @(posedge clk) begin
    req_s1_q <= irq_request;
    req_s2_q <= req_s1_q;
    i2c_s1_q <= i2c_addr_matched;
    i2c_s2_q <= i2c_s1_q;
  end

  function automatic logic [SRC_N-1:0] qualify(
    input logic [SRC_N-1:0] req,
    input logic [SRC_N-1:0] msk,
    input logic sub_ok,
    input logic i2c_ok);
    logic [SRC_N-1:0] q;
    q = req & ~msk;
    if (!sub_ok) begin
      q[`SRC_RTC] = 1'b0;
      q[`SRC_TMR_J] = 1'b0;
      q[`SRC_TMR_D] = 1'b0;
    end
    if (!i2c_ok) begin
      q[`SRC_I2C] = 1'b0;
    end
    return q;
  endfunction

  // only these inputs are watched while the main clock is gated,
  // so real silicon would run this path from an always-on clock
  logic wake;
  assign wake = |qualify(req_s2_q, irq_mask, subclk_runs_in_stop,
                         i2c_s2_q);
  // raw pins may not feed logic, so a request must be synced before
  // the stop instruction to abort entry; a later one wakes at once
  logic entry_pending;
  assign entry_pending = wake;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  stop_ctrl_pkg::state_type state_q;
  logic accept_q;
  logic [CNT_W-1:0] settle_q;

  function automatic logic [CNT_W-1:0] settle_len(
    input logic [`SETTLE_SEL_W-1:0] sel);
    return CNT_W'(`SETTLE_BASE_CYC) << sel;
  endfunction

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= stop_ctrl_pkg::ST_RUN;
    end else begin
      case (state_q)
        stop_ctrl_pkg::ST_RUN: begin
          if (stop_exec && !entry_pending) begin
            state_q <= stop_ctrl_pkg::ST_STOP;
          end
        end
        stop_ctrl_pkg::ST_STOP: begin
          if (wake) begin
            state_q <= stop_ctrl_pkg::ST_SETTLE;
          end
        end
        stop_ctrl_pkg::ST_SETTLE: begin
          if (settle_q == '0) begin
            state_q <= stop_ctrl_pkg::ST_RUN;
          end
        end
        default: state_q <= stop_ctrl_pkg::ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      settle_q <= '0;
    end else if (state_q == stop_ctrl_pkg::ST_STOP && wake) begin
      settle_q <= settle_len(osc_settle_time_select) - 1'b1;
    end else if (settle_q != '0) begin
      settle_q <= settle_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      accept_q <= 1'b0;
    end else if (state_q == stop_ctrl_pkg::ST_RUN && stop_exec) begin
      accept_q <= irq_accept_on;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  logic resume_now;
  assign resume_now = (state_q == stop_ctrl_pkg::ST_SETTLE &&
                       settle_q == '0) ||
                      (state_q == stop_ctrl_pkg::ST_RUN && stop_exec &&
                       entry_pending);
  logic resume_accept;
  assign resume_accept = (state_q == stop_ctrl_pkg::ST_RUN) ?
                         irq_accept_on : accept_q;
  logic wdt_stops;
  // option byte straps only; no runtime register can change it
  assign wdt_stops = watchdog_enable_option &&
                     !watchdog_standby_run_option;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      resume_vector <= 1'b0;
      resume_next <= 1'b0;
    end else begin
      resume_vector <= resume_now && resume_accept;
      resume_next <= resume_now && !resume_accept;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      main_osc_run <= 1'b1;
      cpu_clk_en <= 1'b1;
      stopped <= 1'b0;
    end else begin
      main_osc_run <= !(state_q == stop_ctrl_pkg::ST_RUN && stop_exec &&
                        !entry_pending) &&
                      !(state_q == stop_ctrl_pkg::ST_STOP && !wake);
      cpu_clk_en <= (state_q == stop_ctrl_pkg::ST_RUN && !(stop_exec &&
                     !entry_pending)) || resume_now;
      stopped <= (state_q == stop_ctrl_pkg::ST_RUN && stop_exec &&
                  !entry_pending) ||
                 (state_q == stop_ctrl_pkg::ST_STOP && !wake);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wdt_osc_run <= 1'b1;
      wdt_counter_clr <= 1'b0;
    end else begin
      wdt_osc_run <= !(wdt_stops &&
                       state_q == stop_ctrl_pkg::ST_STOP);
      wdt_counter_clr <= wdt_stops &&
                         state_q == stop_ctrl_pkg::ST_STOP && wake;
    end
  end

  // pll state passes through untouched
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pll_run <= 1'b0;
    end else begin
      pll_run <= pll_run_bit;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_stop_entry_gates: assert property (
    state_q == stop_ctrl_pkg::ST_RUN && stop_exec && !entry_pending
    |=> !cpu_clk_en && !main_osc_run && stopped)
    else $error("stop entry did not gate clocks");
  a_masked_no_wake: assert property (
    state_q == stop_ctrl_pkg::ST_STOP && !wake
    |=> state_q == stop_ctrl_pkg::ST_STOP)
    else $error("left stop without wake");
  a_vector_resume: assert property (
    state_q == stop_ctrl_pkg::ST_SETTLE && settle_q == '0 && accept_q
    |=> resume_vector && !resume_next)
    else $error("vector resume missing");
  a_next_resume: assert property (
    state_q == stop_ctrl_pkg::ST_SETTLE && settle_q == '0 && !accept_q
    |=> resume_next && !resume_vector)
    else $error("next instruction resume missing");
  a_pending_exit: assert property (
    state_q == stop_ctrl_pkg::ST_RUN && stop_exec && entry_pending
    |=> state_q == stop_ctrl_pkg::ST_RUN && cpu_clk_en)
    else $error("pending request did not abort stop");
  a_reset_ends_stop: assert property (@(posedge clk)
    disable iff (1'b0)
    sys_rst |=> state_q == stop_ctrl_pkg::ST_RUN && cpu_clk_en)
    else $error("reset did not end stop");
  a_wdt_osc_stop: assert property (
    state_q == stop_ctrl_pkg::ST_STOP && $past(state_q) ==
    stop_ctrl_pkg::ST_STOP |-> wdt_osc_run == !wdt_stops)
    else $error("watchdog oscillator state wrong");
  a_settle_wait: assert property (
    state_q == stop_ctrl_pkg::ST_STOP && wake
    |=> !cpu_clk_en [*8])
    else $error("cpu clock restored before settling");
  a_pll_kept: assert property (
    pll_run_bit |=> pll_run)
    else $error("pll state not kept");

  c_stop_wake: cover property (
    state_q == stop_ctrl_pkg::ST_STOP ##1
    state_q == stop_ctrl_pkg::ST_SETTLE);
  c_vector: cover property (resume_vector);
  c_next: cover property (resume_next);
  c_abort: cover property (
    state_q == stop_ctrl_pkg::ST_RUN && stop_exec && entry_pending);
endmodule

// ---- include/stop_ctrl_cfg.svh ----
// constants for the stop mode standby controller
`ifndef STOP_CTRL_CFG_SVH
`define STOP_CTRL_CFG_SVH
`define SRC_COUNT 16
`define SETTLE_SEL_W 3
`define SETTLE_BASE_NS 80
`define CLK_PERIOD_NS 10
`define SETTLE_BASE_CYC ((`SETTLE_BASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_CNT_W 20
`define SRC_I2C 4
`define SRC_RTC 0
`define SRC_TMR_J 1
`define SRC_TMR_D 2
`endif

// ---- include/stop_ctrl_pkg.sv ----
// types for the stop mode standby controller
package stop_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_STOP = 2'b01,
    ST_SETTLE = 2'b10
  } state_type;
endpackage

// ---- bench/irq_source_model.sv ----
// peripheral request sources facing the standby controller
`timescale 1ns/10ps
module irq_source_model (
  input wire logic clk,
  input wire logic [3:0] fire_idx,
  input wire logic fire,
  input wire logic clr,
  output logic [15:0] irq_request
);
  // flags hold until software clears them
  always_ff @(posedge clk) begin
    if (clr) begin
      irq_request <= 16'h0000;
    end else if (fire) begin
      irq_request[fire_idx] <= 1'b1;
    end
  end
endmodule

// ---- bench/test_stop_mode_standby_control.sv ----
// self-checking bench for the stop mode standby controller
`timescale 1ns/10ps
module test_stop_mode_standby_control;
  logic clk, sys_rst, stop_exec, acc_on, sub, i2c, wen, wsb, pll_bit;
  logic fire, clr, seen;
  logic [15:0] irq_mask, irq_request;
  logic [2:0] sel;
  logic [3:0] idx;
  logic osc, cpu_en, stopped, r_vec, r_next, wdt_osc, wdt_clr, pll_run;
  int fails, checked, n, cyc, e;
  int exp_q[$];
  logic [31:0] lfsr;
  stop_mode_standby_control u_stop_mode_standby_control (.clk(clk),
    .sys_rst(sys_rst), .stop_exec(stop_exec), .irq_accept_on(acc_on),
    .irq_request(irq_request), .irq_mask(irq_mask),
    .subclk_runs_in_stop(sub), .i2c_addr_matched(i2c),
    .osc_settle_time_select(sel), .watchdog_enable_option(wen),
    .watchdog_standby_run_option(wsb), .pll_run_bit(pll_bit),
    .main_osc_run(osc), .cpu_clk_en(cpu_en), .stopped(stopped),
    .resume_vector(r_vec), .resume_next(r_next), .wdt_osc_run(wdt_osc),
    .wdt_counter_clr(wdt_clr), .pll_run(pll_run));
  irq_source_model u_irq_source_model (.clk(clk), .fire_idx(idx),
    .fire(fire), .clr(clr), .irq_request(irq_request));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, longest trial is a few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end
  task automatic results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic g, input logic x);
    checked++;
    if (g !== x) begin
      fails++;
      $display("[FAIL] %0t mismatch got %b exp %b", $time, g, x);
    end
  endtask
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // observed outcome: 0 none, 1 vectored, 2 next instruction
  function automatic int obs();
    return r_vec === 1'b1 ? 1 : (r_next === 1'b1 ? 2 : 0);
  endfunction
  task automatic trial(input logic [3:0] i, input logic a, m, s, c, w, p);
    e = !m && !(i < 3 && !s) && !(i == 4 && !c);
    exp_q.push_back((p || e) ? 2 - a : 0);
    @(posedge clk);
    idx <= i; acc_on <= a; sub <= s; i2c <= c; wsb <= w;
    irq_mask <= m ? 16'hFFFF : ~(16'h0001 << i);
    if (p) begin
      fire <= 1'b1;
      repeat (3) @(posedge clk);
      fire <= 1'b0;
    end
    stop_exec <= 1'b1;
    @(posedge clk);
    stop_exec <= 1'b0;
    #1;
    if (p) begin
      chk(r_vec | r_next, 1'b1);
      chk(obs() == exp_q.pop_front(), 1'b1);
    end else begin
      chk(stopped, 1'b1);
      chk(cpu_en | osc, 1'b0);
      @(posedge clk);
      #1 chk(wdt_osc, ~wen | w);
      fire <= 1'b1;
      n = 0;
      seen = 1'b0;
      while ((r_vec | r_next) !== 1'b1 && n < 200) begin
        @(posedge clk);
        fire <= 1'b0;
        #1 n++;
        seen |= wdt_clr === 1'b1;
      end
      chk(obs() == exp_q.pop_front(), 1'b1);
      if (e) begin
        chk(osc & ~stopped, 1'b1);
        chk(r_vec, a);
        chk(r_next, ~a);
        chk(n >= (8 << sel) && n <= (8 << sel) + 5, 1'b1);
        chk(seen, ~w);
        chk(cpu_en, 1'b1);
      end else begin
        chk(stopped, 1'b1);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1 chk(stopped | ~cpu_en, 1'b0);
      end
    end
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    // let the cleared flags pass the synchroniser before the next stop
    repeat (2) @(posedge clk);
  endtask
  initial begin
    {stop_exec, acc_on, sub, i2c, wsb, pll_bit, fire} = 7'h00;
    sys_rst = 1'b1; clr = 1'b1; wen = 1'b1; sel = 3'h0; idx = 4'h0;
    irq_mask = 16'hFFFF; lfsr = 32'h8C45;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0; clr <= 1'b0; pll_bit <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(pll_run & cpu_en & osc & ~stopped, 1'b1);
    @(posedge clk);
    pll_bit <= 1'b0;
    trial(4'h5, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    trial(4'h6, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    trial(4'h7, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    trial(4'h1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    trial(4'h2, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    trial(4'h4, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    trial(4'h4, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    trial(4'h9, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    for (int k = 0; k < 6; k++) begin
      lfsr = nxt(lfsr);
      sel <= {1'b0, lfsr[1:0]};
      trial(4'h5 + (lfsr[7:4] % 11), lfsr[8], 1'b0, lfsr[9], 1'b0,
        lfsr[10], 1'b0);
    end
    #1 chk(pll_run, 1'b0);
    results();
  end
endmodule
